// ===== core/sgw_pkg.sv
// Function
// - Guard period defaults to ten seconds
// - Guard period programmable from 1 to 15 s
// - Host may disable guard timer after power-up
// - Uncleared guard expiry asserts standby output
// - Guard runs from reset; also starts on wake rising edge, or on ready rising edge if kept on
// - Clear bit resets guard count
// - Resume held count; boot restarts from period
// - Watchdog register 09h: multiplier and resolution
// - Resolution codes select 1/16 s to 1 min
// - Timeout equals multiplier times resolution unit
// - Value 00h disables and clears watchdog
// - Watchdog off after power-on until write with nonzero multiplier and valid resolution
// - Every write to 09h restarts timeout, unless the value disables the watchdog
// - Elapsed timeout sets watchdog flag
// - Ready rise while running turns guard off unless kept on
// - Standby release on wake starts guard
// - Guard stays stopped during standby
// - Standby output low normally, high cuts power
package sgw_pkg;
  localparam logic [7:0] WD_REG_ADDR = 8'h09;
  localparam logic [7:0] WD_REG_RESET = 8'h00;
  localparam int WD_MULT_LSB = 3;
  localparam int WD_MULT_W = 5;
  localparam int WD_RES_LSB = 0;
  localparam int WD_RES_W = 3;
  localparam logic [3:0] GUARD_DEFAULT_S = 4'ha;
  localparam logic [3:0] GUARD_MIN_S = 4'h1;
  localparam int XTAL_HZ = 32768;
  localparam int CLK_HZ = 10000000;
  // Crystal edges per sixteenth second
  localparam int XTAL_PER_TICK16 = XTAL_HZ / 16;
  localparam logic [2:0] RES_16TH = 3'h0;
  localparam logic [2:0] RES_QUARTER = 3'h1;
  localparam logic [2:0] RES_SECOND = 3'h2;
  localparam logic [2:0] RES_FOUR = 3'h3;
  localparam logic [2:0] RES_MINUTE = 3'h4;
  // Sixteenth-second ticks per resolution unit
  localparam logic [10:0] TICKS_16TH = 11'h001;
  localparam logic [10:0] TICKS_QUARTER = 11'h004;
  localparam logic [10:0] TICKS_SECOND = 11'h010;
  localparam logic [10:0] TICKS_FOUR = 11'h040;
  localparam logic [10:0] TICKS_MINUTE = 11'h3c0;
endpackage

// ===== core/sgw_if.sv
`timescale 1ns/1ps
interface sgw_if;
  logic host_ready;
  logic wake;
  logic board_power_cut_out;
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic guard_clear;
  logic guard_disable;
  logic guard_keep_on;
  logic [3:0] guard_period;
  logic guard_period_wr;
  logic wd_flag;
  modport dev (
    input host_ready, wake, reg_wr, reg_addr, reg_wdata, guard_clear, guard_disable,
    input guard_keep_on, guard_period, guard_period_wr,
    output board_power_cut_out, reg_rdata, wd_flag
  );
  modport host (
    output host_ready, wake, reg_wr, reg_addr, reg_wdata, guard_clear, guard_disable,
    output guard_keep_on, guard_period, guard_period_wr,
    input board_power_cut_out, reg_rdata, wd_flag
  );
endinterface

// ===== core/sgw_tick_div.sv
`timescale 1ns/1ps
// Divides the crystal strobe into a sixteenth-second pulse
module sgw_tick_div #(
  parameter int DIV = sgw_pkg::XTAL_PER_TICK16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic xtal_tick_i,
  output logic tick16_o
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } sgw_div_st_t;
  sgw_div_st_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (xtal_tick_i) begin
      if (s_q.cnt == 16'(DIV - 1)) begin
        s_d.cnt = 16'h0000;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick16_o = s_q.tick;
endmodule // sgw_tick_div

// ===== core/sgw_device.sv
`timescale 1ns/1ps
// Front-panel supervisor: guard timer and watchdog
module sgw_device (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic xtal_tick_i,
  input wire logic standby_cmd_i,
  input wire logic wake_source_i,
  sgw_if.dev bus
);
  typedef enum logic [1:0] {ST_RUN, ST_STANDBY} sgw_pwr_t;
  typedef struct packed {
    sgw_pwr_t pwr;
    logic ready_prev;
    logic wake_prev;
    logic g_run;
    logic g_disabled;
    logic g_keep_on;
    logic [3:0] g_period;
    logic [3:0] g_secs;
    logic [3:0] g_sub;
    logic cut;
    logic [7:0] wd_reg;
    logic [15:0] wd_cnt;
    logic [10:0] wd_unit;
    logic wd_run;
    logic wd_flag;
    logic [7:0] rdata;
  } sgw_dev_st_t;
  sgw_dev_st_t s_q, s_d;
  logic tick16;

  sgw_tick_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .xtal_tick_i(xtal_tick_i),
    .tick16_o(tick16)
  );

  function automatic logic [10:0] res_ticks(input logic [2:0] code);
    unique case (code)
      sgw_pkg::RES_16TH: res_ticks = sgw_pkg::TICKS_16TH;
      sgw_pkg::RES_QUARTER: res_ticks = sgw_pkg::TICKS_QUARTER;
      sgw_pkg::RES_SECOND: res_ticks = sgw_pkg::TICKS_SECOND;
      sgw_pkg::RES_FOUR: res_ticks = sgw_pkg::TICKS_FOUR;
      sgw_pkg::RES_MINUTE: res_ticks = sgw_pkg::TICKS_MINUTE;
      default: res_ticks = 11'h000;
    endcase
  endfunction

  logic ready_rise, wake_rise, ready_fall, wd_wr;
  logic [4:0] wr_mult;
  logic [10:0] wr_unit;
  assign ready_rise = bus.host_ready && !s_q.ready_prev;
  assign ready_fall = !bus.host_ready && s_q.ready_prev;
  assign wake_rise = bus.wake && !s_q.wake_prev;
  assign wd_wr = bus.reg_wr && (bus.reg_addr == sgw_pkg::WD_REG_ADDR);
  assign wr_mult = bus.reg_wdata[sgw_pkg::WD_MULT_LSB +: sgw_pkg::WD_MULT_W];
  assign wr_unit = res_ticks(bus.reg_wdata[sgw_pkg::WD_RES_LSB +: sgw_pkg::WD_RES_W]);

  always_comb begin
    s_d = s_q;
    s_d.ready_prev = bus.host_ready;
    s_d.wake_prev = bus.wake;
    if (bus.guard_period_wr && bus.guard_period >= sgw_pkg::GUARD_MIN_S) begin
      s_d.g_period = bus.guard_period;
    end
    s_d.g_keep_on = bus.guard_keep_on;
    s_d.g_disabled = bus.guard_disable;
    unique case (s_q.pwr)
      ST_RUN: begin
        s_d.cut = 1'b0;
        if (ready_rise && !s_q.g_keep_on) begin
          s_d.g_run = 1'b0;
        end else if ((ready_rise || wake_rise) && !s_q.g_disabled) begin
          s_d.g_run = 1'b1;
        end
        if (bus.guard_clear) begin
          s_d.g_secs = s_q.g_period;
          s_d.g_sub = 4'h0;
        end else if (s_q.g_run && !s_q.g_disabled && tick16) begin
          // Count resumes from held value
          s_d.g_sub = s_q.g_sub + 4'h1;
          if (s_q.g_sub == 4'hf) begin
            s_d.g_secs = s_q.g_secs - 4'h1;
            if (s_q.g_secs == 4'h1) begin
              s_d.pwr = ST_STANDBY;
              s_d.cut = 1'b1;
              s_d.g_run = 1'b0;
            end
          end
        end
        if (ready_fall || standby_cmd_i) begin
          s_d.pwr = ST_STANDBY;
          s_d.cut = 1'b1;
          s_d.g_run = 1'b0;
        end
      end
      ST_STANDBY: begin
        s_d.g_run = 1'b0;
        s_d.cut = 1'b1;
        if (wake_rise || ready_rise || wake_source_i) begin
          s_d.pwr = ST_RUN;
          s_d.cut = 1'b0;
          s_d.g_run = !s_q.g_disabled;
          s_d.g_secs = s_q.g_period;
          s_d.g_sub = 4'h0;
        end
      end
    endcase
    if (s_q.wd_run && tick16) begin
      if (s_q.wd_cnt == 16'h0001) begin
        s_d.wd_flag = 1'b1;
        s_d.wd_run = 1'b0;
        s_d.wd_cnt = 16'h0000;
      end else begin
        s_d.wd_cnt = s_q.wd_cnt - 16'h0001;
      end
    end
    if (wd_wr) begin
      s_d.wd_reg = bus.reg_wdata;
      s_d.wd_unit = wr_unit;
      s_d.wd_cnt = 16'(wr_mult * wr_unit);
      s_d.wd_run = (bus.reg_wdata != 8'h00) && (wr_unit != 11'h000) && (wr_mult != 5'h00);
      if (bus.reg_wdata == 8'h00) begin
        s_d.wd_cnt = 16'h0000;
      end
    end
    s_d.rdata = (bus.reg_addr == sgw_pkg::WD_REG_ADDR) ? s_q.wd_reg : 8'h00;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.pwr <= ST_RUN;
      s_q.g_period <= sgw_pkg::GUARD_DEFAULT_S;
      s_q.g_secs <= sgw_pkg::GUARD_DEFAULT_S;
      s_q.g_run <= 1'b1;
      s_q.wd_reg <= sgw_pkg::WD_REG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.board_power_cut_out = s_q.cut;
  assign bus.reg_rdata = s_q.rdata;
  assign bus.wd_flag = s_q.wd_flag;
endmodule // sgw_device

// ===== core/sgw_host.sv
`timescale 1ns/1ps
// Host side: drives ready, wake and configuration from user requests
module sgw_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ready_i,
  input wire logic wake_i,
  input wire logic kick_i,
  input wire logic guard_disable_i,
  input wire logic guard_keep_on_i,
  input wire logic period_wr_i,
  input wire logic [3:0] period_i,
  input wire logic wd_wr_i,
  input wire logic [7:0] wd_value_i,
  output logic power_cut_o,
  output logic wd_flag_o,
  output logic [7:0] wd_readback_o,
  sgw_if.host bus
);
  typedef struct packed {
    logic ready;
    logic wake;
    logic clear;
    logic dis;
    logic keep;
    logic pwr;
    logic [3:0] period;
    logic wr;
    logic [7:0] wdata;
  } sgw_host_st_t;
  sgw_host_st_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.ready = ready_i;
    s_d.wake = wake_i;
    s_d.clear = kick_i;
    s_d.dis = guard_disable_i;
    s_d.keep = guard_keep_on_i;
    s_d.pwr = period_wr_i;
    s_d.wr = wd_wr_i;
    if (period_wr_i) begin
      s_d.period = period_i;
    end
    if (wd_wr_i) begin
      s_d.wdata = wd_value_i;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign bus.host_ready = s_q.ready;
  assign bus.wake = s_q.wake;
  assign bus.guard_clear = s_q.clear;
  assign bus.guard_disable = s_q.dis;
  assign bus.guard_keep_on = s_q.keep;
  assign bus.guard_period = s_q.period;
  assign bus.guard_period_wr = s_q.pwr;
  assign bus.reg_wr = s_q.wr;
  assign bus.reg_addr = sgw_pkg::WD_REG_ADDR;
  assign bus.reg_wdata = s_q.wdata;
  assign power_cut_o = bus.board_power_cut_out;
  assign wd_flag_o = bus.wd_flag;
  assign wd_readback_o = bus.reg_rdata;
endmodule // sgw_host

// ===== testbench/sgw_assertions.sv
`timescale 1ns/1ps
module sgw_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic host_ready,
  input wire logic wake,
  input wire logic board_power_cut_out,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic wd_flag
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wd_wr;
  assign wd_wr = reg_wr && (reg_addr == sgw_pkg::WD_REG_ADDR);
  property rdata_follows;
    logic [7:0] v;
    (wd_wr, v = reg_wdata) ##1 (!reg_wr && reg_addr == sgw_pkg::WD_REG_ADDR) [*2]
      |-> reg_rdata == v;
  endproperty
  chk_wd_readback: assert property (rdata_follows)
    else $error("readback differs from write");
  chk_flag_sticky: assert property (wd_flag |=> wd_flag)
    else $error("flag dropped");
  chk_zero_stops: assert property (wd_wr && reg_wdata == 8'h00 ##1 !wd_flag |=> !wd_flag [*8])
    else $error("flag after stop");
  chk_write_restarts: assert property (wd_wr |=> ##2 (!$rose(wd_flag)) [*6])
    else $error("flag right after restart");
  chk_cut_low_boot: assert property ($fell(rst_i) |-> !board_power_cut_out)
    else $error("power cut at boot");
  chk_flag_off_boot: assert property ($fell(rst_i) |-> !wd_flag)
    else $error("flag at boot");
  chk_wake_release: assert property (board_power_cut_out && $rose(wake)
    |-> ##[1:4] !board_power_cut_out)
    else $error("wake kept power cut");
  chk_ready_fall_cut: assert property ($fell(host_ready) |-> ##[1:4] board_power_cut_out)
    else $error("ready fall left power on");
  cover property ($rose(wd_flag));
  cover property ($rose(board_power_cut_out));
  cover property ($fell(board_power_cut_out));
endmodule // sgw_assertions

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [1:0] ev;
    int unsigned lo;
    int unsigned hi;
  } sgw_note_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic xt = 1'b0, rdy = 1'b0, wk = 1'b0, kick = 1'b0, pwr = 1'b0, wwr = 1'b0;
  logic [3:0] per = 4'h0;
  logic [7:0] wval = 8'h00;
  logic [7:0] rv;
  logic cut, flag;
  logic [7:0] rb;
  logic [1:0] prev;
  int unsigned cyc = 0, t0, t1;
  int mismatches = 0;
  int num_checks = 0;
  sgw_note_t notes[$];
  sgw_note_t n;
  sgw_if bus_if ();
  sgw_device sgw_device_i (.clk_i(clk_i), .rst_i(rst_i), .xtal_tick_i(xt),
    .standby_cmd_i(1'b0), .wake_source_i(1'b0), .bus(bus_if));
  sgw_host sgw_host_i (.clk_i(clk_i), .rst_i(rst_i), .ready_i(rdy), .wake_i(wk), .kick_i(kick),
    .guard_disable_i(1'b0), .guard_keep_on_i(1'b0), .period_wr_i(pwr), .period_i(per),
    .wd_wr_i(wwr), .wd_value_i(wval), .power_cut_o(cut), .wd_flag_o(flag),
    .wd_readback_o(rb), .bus(bus_if));
  sgw_assertions sgw_assertions_i (.clk_i(clk_i), .rst_i(rst_i), .host_ready(bus_if.host_ready),
    .wake(bus_if.wake), .board_power_cut_out(bus_if.board_power_cut_out),
    .reg_wr(bus_if.reg_wr), .reg_addr(bus_if.reg_addr), .reg_wdata(bus_if.reg_wdata),
    .reg_rdata(bus_if.reg_rdata), .wd_flag(bus_if.wd_flag));
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    xt <= #5 ~xt;
  end
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #5;
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_time(input int unsigned at, input int unsigned lo, input int unsigned hi);
    num_checks++;
    if (at < lo || at > hi) begin
      mismatches++;
      $display("[FAIL] t=%0t cycle=%h window=%h..%h", $time, at, lo, hi);
    end
  endtask
  task automatic expect_ev(input logic [1:0] ev, input int unsigned lo, input int unsigned hi);
    notes.push_back(sgw_note_t'{ev, lo, hi});
  endtask
  task automatic wd_write(input logic [7:0] v);
    wval = v;
    wwr = 1'b1;
    step(1);
    wwr = 1'b0;
    step(4);
    check_byte(rb, v);
  endtask
  task automatic drain(input int limit);
    int k;
    k = 0;
    while (notes.size() != 0 && k < limit) begin
      step(1);
      k++;
    end
    if (notes.size() != 0) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic boot;
    rst_i = 1'b1;
    step(12);
    rst_i = 1'b0;
    step(1);
  endtask
  // Any change of cut or flag must match the oldest note, in value and cycle
  always @(negedge clk_i) begin
    if (rst_i) begin
      prev = {cut, flag};
    end else if ({cut, flag} !== prev) begin
      prev = {cut, flag};
      n = (notes.size() != 0) ? notes.pop_front() : sgw_note_t'{~prev, 0, 0};
      check_byte({6'h00, prev}, {6'h00, n.ev});
      check_time(cyc, n.lo, n.hi);
    end
  end
  initial begin
    void'($urandom(32'hfa3a));
    boot();
    t0 = cyc;
    wd_write(8'h10);
    step(7000);
    t0 = cyc;
    wd_write(8'h10);
    expect_ev(2'b01, t0 + 4096, t0 + 8216);
    drain(9000);
    boot();
    per = 4'h1;
    pwr = 1'b1;
    step(1);
    pwr = 1'b0;
    kick = 1'b1;
    step(1);
    kick = 1'b0;
    t0 = cyc;
    wd_write(8'h08);
    wd_write(8'h00);
    rv = 8'($urandom);
    wd_write({rv[7:3] | 5'h01, 3'h5 + 3'(rv % 3)});
    step(10000);
    t1 = cyc;
    wd_write(8'h09);
    expect_ev(2'b01, t1 + 12288, t1 + 16408);
    expect_ev(2'b11, t0 + 61440, t0 + 65560);
    drain(70000);
    wk = 1'b1;
    expect_ev(2'b01, cyc, cyc + 8);
    drain(20);
    rdy = 1'b1;
    step(4);
    rdy = 1'b0;
    expect_ev(2'b11, cyc, cyc + 8);
    drain(20);
    complete_run();
  end
endmodule // testbench
